// >>> src/adc_status_pkg.sv
// Functional notes
// - set sequence done flag per finished sequence
// - clear done: write one, start write, fast read
// - edge mode: trigger during sequence sets overrun
// - clear overrun: write one, abort, start write
// - result over unread done flag sets overwrite
// - clear overwrite: write one or new start
// - three bit read only pointer names result
// - non fifo: pointer zeroed at start, end
// - pointer wraps from seven to zero
// - control write or abort zeroes pointer always
// - reserved test zero writable only special mode
// - special enable turns code into internal source
// - codes 100,101,110 pick high, low, mid reference
// - test one bits seven, six read undefined
// - per position done flag set per conversion
// - scan setting repeats sequences or runs once
package adc_status_pkg;

  localparam int RESULT_W = 10;
  localparam int NUM_RESULTS = 8;
  localparam int PTR_W = 3;

  typedef logic [5:0] regIndex_t;
  // printed offsets are register indexes; byte address is index times four
  localparam regIndex_t IDX_CTL2 = 6'h02;
  localparam regIndex_t IDX_CTL3 = 6'h03;
  localparam regIndex_t IDX_CTL4 = 6'h04;
  localparam regIndex_t IDX_CTL5 = 6'h05;
  localparam regIndex_t IDX_STATUS0 = 6'h06;
  localparam regIndex_t IDX_TEST0 = 6'h08;
  localparam regIndex_t IDX_TEST1 = 6'h09;
  localparam regIndex_t IDX_CONV_DONE = 6'h0b;
  localparam regIndex_t IDX_IRQ_STATUS = 6'h0c;
  localparam regIndex_t IDX_IRQ_MASK = 6'h0d;
  localparam regIndex_t IDX_RESULT_BASE = 6'h10;
  localparam regIndex_t IDX_RESULT_LAST = 6'h17;

  localparam int STAT_SEQ_DONE_BIT = 7;
  localparam int STAT_TRIG_OVR_BIT = 5;
  localparam int STAT_OVERWRITE_BIT = 4;

  localparam int CTL2_FAST_CLEAR_BIT = 6;
  localparam int CTL2_TRIG_LEVEL_BIT = 4;
  localparam int CTL2_TRIG_POL_BIT = 3;
  localparam int CTL2_TRIG_EN_BIT = 2;
  localparam int CTL3_FIFO_BIT = 2;
  localparam int CTL5_SCAN_BIT = 5;
  localparam int TEST1_SPECIAL_BIT = 0;

  localparam int IRQ_W = 3;
  localparam int IRQ_SEQ_DONE = 0;
  localparam int IRQ_TRIG_OVR = 1;
  localparam int IRQ_OVERWRITE = 2;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'h0,
    SRC_REF_HIGH = 3'h1,
    SRC_REF_LOW = 3'h3,
    SRC_REF_MID = 3'h2,
    SRC_RESERVED = 3'h6
  } source_e;

  typedef struct packed {
    source_e source;
    logic [2:0] channel;
  } analogSelect_s;

  typedef struct packed {
    logic valid;
    logic [RESULT_W-1:0] data;
  } convResult_s;

endpackage

// >>> src/adc_channel_decode.sv
`timescale 1ns/1ns
module adc_channel_decode
  import adc_status_pkg::*;
(
  input wire logic specialEnable,
  input wire logic [2:0] channelSelectCode,
  output analogSelect_s select
);

  always_comb begin
    select.channel = channelSelectCode;
    if (!specialEnable) begin
      select.source = SRC_EXTERNAL;
    end else begin
      case (channelSelectCode)
        3'h4: select.source = SRC_REF_HIGH;
        3'h5: select.source = SRC_REF_LOW;
        3'h6: select.source = SRC_REF_MID;
        default: select.source = SRC_RESERVED;
      endcase
    end
  end

endmodule // adc_channel_decode

// >>> src/adc_status_test_regs.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module adc_status_test_regs
  import adc_status_pkg::*;
#(
  parameter int RESULTS = NUM_RESULTS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic specialMode,
  input wire logic extTrigger,
  input wire logic seqActive,
  input wire logic seqEnd,
  input wire convResult_s convResult,
  output logic seqStart,
  output logic seqAbort,
  output logic scanMode,
  output logic fifoMode,
  output analogSelect_s analogSelect,
  output logic irq
);

  // bus state
  logic awHeld_q, awHeld_d;
  logic wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [7:0] wData_q, wData_d;
  logic wLane_q, wLane_d;
  logic awReady_q, awReady_d;
  logic wReady_q, wReady_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic arReady_q, arReady_d;
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;

  // core state
  logic [7:0] ctl2_q, ctl2_d, ctl3_q, ctl3_d, ctl4_q, ctl4_d, ctl5_q, ctl5_d;
  logic [7:0] test0_q, test0_d, test1_q, test1_d;
  logic seqDoneFlag_q, seqDoneFlag_d;
  logic trigOverrunFlag_q, trigOverrunFlag_d;
  logic overwriteFlag_q, overwriteFlag_d;
  logic [PTR_W-1:0] convPointer_q, convPointer_d;
  logic [RESULTS-1:0] convDoneFlag_q, convDoneFlag_d;
  logic doneReadArmed_q, doneReadArmed_d;
  logic [RESULT_W-1:0] results_q [RESULTS];
  logic [RESULT_W-1:0] results_d [RESULTS];
  logic [IRQ_W-1:0] irqStatus_q, irqStatus_d, irqMask_q, irqMask_d;
  logic [2:0] trigSync_q, trigSync_d;
  logic seqStart_q, seqStart_d, seqAbort_q, seqAbort_d;
  logic irq_q, irq_d;
  analogSelect_s analogSelect_q, analogSelectNext;

  // decoded bus events
  logic wrEn, rdEn;
  regIndex_t wrIdx, rdIdx;
  logic wrHit, rdHit;
  logic [31:0] rdValue;
  logic rdResult, rdConvDone, rdIrqStatus;
  logic [PTR_W-1:0] rdResultSel;

  // core events
  logic wrCtl2, wrCtl3, wrCtl4, wrCtl5, wrStatus, abortWrite;
  logic trigEdge, trigLevel, trigStart, anyStart;
  logic fastClear, edgeMode;
  logic overwriteEvent, trigOverrunEvent;
  logic [IRQ_W-1:0] irqEvents;

  assign fastClear = ctl2_q[CTL2_FAST_CLEAR_BIT];
  assign edgeMode = !ctl2_q[CTL2_TRIG_LEVEL_BIT];

  adc_channel_decode channelDecode (
    .specialEnable(test1_q[TEST1_SPECIAL_BIT]),
    .channelSelectCode(ctl5_q[2:0]),
    .select(analogSelectNext)
  );

  // ---------------- AXI4-Lite slave ----------------
  assign wrEn = awHeld_q && wHeld_q && !bValid_q;
  assign wrIdx = awAddr_q[7:2];
  assign rdEn = s_axi_arvalid && arReady_q;
  assign rdIdx = s_axi_araddr[7:2];
  assign rdResult = rdEn && rdIdx >= IDX_RESULT_BASE && rdIdx <= IDX_RESULT_LAST;
  assign rdResultSel = rdIdx[PTR_W-1:0];
  assign rdConvDone = rdEn && rdIdx == IDX_CONV_DONE;
  assign rdIrqStatus = rdEn && rdIdx == IDX_IRQ_STATUS;

  always_comb begin
    wrHit = 1'b1;
    case (wrIdx)
      IDX_CTL2, IDX_CTL3, IDX_CTL4, IDX_CTL5, IDX_STATUS0, IDX_TEST0, IDX_TEST1,
      IDX_IRQ_MASK, IDX_CONV_DONE, IDX_IRQ_STATUS: wrHit = 1'b1;
      default: wrHit = wrIdx >= IDX_RESULT_BASE && wrIdx <= IDX_RESULT_LAST;
    endcase
  end

  always_comb begin
    rdHit = 1'b1;
    rdValue = 32'h0;
    case (rdIdx)
      IDX_CTL2: rdValue[7:0] = ctl2_q;
      IDX_CTL3: rdValue[7:0] = ctl3_q;
      IDX_CTL4: rdValue[7:0] = ctl4_q;
      IDX_CTL5: rdValue[7:0] = ctl5_q;
      IDX_STATUS0: begin
        rdValue[STAT_SEQ_DONE_BIT] = seqDoneFlag_q;
        rdValue[STAT_TRIG_OVR_BIT] = trigOverrunFlag_q;
        rdValue[STAT_OVERWRITE_BIT] = overwriteFlag_q;
        rdValue[PTR_W-1:0] = convPointer_q;
      end
      // content is not guaranteed; the stored byte is returned
      IDX_TEST0: rdValue[7:0] = test0_q;
      IDX_TEST1: rdValue[7:0] = test1_q;
      IDX_CONV_DONE: rdValue[RESULTS-1:0] = convDoneFlag_q;
      IDX_IRQ_STATUS: rdValue[IRQ_W-1:0] = irqStatus_q;
      IDX_IRQ_MASK: rdValue[IRQ_W-1:0] = irqMask_q;
      default: begin
        rdHit = rdIdx >= IDX_RESULT_BASE && rdIdx <= IDX_RESULT_LAST;
        if (rdHit) begin
          rdValue[RESULT_W-1:0] = results_q[rdResultSel];
        end
      end
    endcase
  end

  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wLane_d = wLane_q;
    awReady_d = awReady_q;
    wReady_d = wReady_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    arReady_d = arReady_q;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_awvalid && awReady_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
      awReady_d = 1'b0;
    end
    if (s_axi_wvalid && wReady_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata[7:0];
      wLane_d = s_axi_wstrb[0];
      wReady_d = 1'b0;
    end
    if (wrEn) begin
      bValid_d = 1'b1;
      bResp_d = wrHit ? RESP_OKAY : RESP_SLVERR;
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
      awReady_d = 1'b1;
      wReady_d = 1'b1;
    end
    if (rdEn) begin
      arReady_d = 1'b0;
      rValid_d = 1'b1;
      rData_d = rdValue;
      rResp_d = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
      arReady_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 8'h00;
      wLane_q <= 1'b0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h0;
      rResp_q <= RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wLane_q <= wLane_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  // ---------------- converter status core ----------------
  // a write without byte lane zero carries no register data and has no side effect
  assign wrCtl2 = wrEn && wLane_q && wrIdx == IDX_CTL2;
  assign wrCtl3 = wrEn && wLane_q && wrIdx == IDX_CTL3;
  assign wrCtl4 = wrEn && wLane_q && wrIdx == IDX_CTL4;
  assign wrCtl5 = wrEn && wLane_q && wrIdx == IDX_CTL5;
  assign wrStatus = wrEn && wLane_q && wrIdx == IDX_STATUS0;
  assign abortWrite = wrCtl2 || wrCtl3 || wrCtl4;

  // change counts when stage two differs from stage three and matches the polarity
  assign trigEdge = (trigSync_q[1] != trigSync_q[2])
      && (trigSync_q[1] == ctl2_q[CTL2_TRIG_POL_BIT]);
  assign trigLevel = trigSync_q[2] == ctl2_q[CTL2_TRIG_POL_BIT];
  assign trigStart = ctl2_q[CTL2_TRIG_EN_BIT] && !seqActive && !seqStart_q
      && (edgeMode ? trigEdge : trigLevel);
  assign anyStart = wrCtl5 || trigStart;
  assign trigOverrunEvent = ctl2_q[CTL2_TRIG_EN_BIT] && edgeMode && trigEdge
      && seqActive;
  assign overwriteEvent = convResult.valid && convDoneFlag_q[convPointer_q];
  assign irqEvents = {overwriteEvent, trigOverrunEvent, seqEnd};

  always_comb begin
    ctl2_d = ctl2_q;
    ctl3_d = ctl3_q;
    ctl4_d = ctl4_q;
    ctl5_d = ctl5_q;
    test0_d = test0_q;
    test1_d = test1_q;
    irqMask_d = irqMask_q;
    seqDoneFlag_d = seqDoneFlag_q;
    trigOverrunFlag_d = trigOverrunFlag_q;
    overwriteFlag_d = overwriteFlag_q;
    convPointer_d = convPointer_q;
    convDoneFlag_d = convDoneFlag_q;
    doneReadArmed_d = doneReadArmed_q;
    results_d = results_q;
    trigSync_d = {trigSync_q[1:0], extTrigger};
    seqStart_d = anyStart;
    seqAbort_d = abortWrite;

    if (wrCtl2) ctl2_d = wData_q;
    if (wrCtl3) ctl3_d = wData_q;
    if (wrCtl4) ctl4_d = wData_q;
    if (wrCtl5) ctl5_d = wData_q;
    if (wrEn && wLane_q && wrIdx == IDX_TEST0 && specialMode) test0_d = wData_q;
    // upper bits are kept as written; software owns keeping them zero
    if (wrEn && wLane_q && wrIdx == IDX_TEST1) test1_d = wData_q;
    if (wrEn && wLane_q && wrIdx == IDX_IRQ_MASK) irqMask_d = wData_q[IRQ_W-1:0];

    // clears first, hardware sets last so a coincident event survives
    if ((wrStatus && wData_q[STAT_SEQ_DONE_BIT]) || wrCtl5
        || (fastClear && rdResult)) begin
      seqDoneFlag_d = 1'b0;
    end
    if ((wrStatus && wData_q[STAT_TRIG_OVR_BIT]) || abortWrite || wrCtl5) begin
      trigOverrunFlag_d = 1'b0;
    end
    if ((wrStatus && wData_q[STAT_OVERWRITE_BIT]) || anyStart) begin
      overwriteFlag_d = 1'b0;
    end

    if (rdConvDone) doneReadArmed_d = 1'b1;
    if (rdResult && (fastClear || doneReadArmed_q)) begin
      convDoneFlag_d[rdResultSel] = 1'b0;
      doneReadArmed_d = 1'b0;
    end
    if (wrCtl5) convDoneFlag_d = '0;

    // pointer: status writes never reach it
    if (abortWrite || wrCtl5) begin
      convPointer_d = '0;
    end else if (trigStart && !fifoMode) begin
      convPointer_d = '0;
    end else if (convResult.valid) begin
      results_d[convPointer_q] = convResult.data;
      convDoneFlag_d[convPointer_q] = 1'b1;
      convPointer_d = convPointer_q + 3'h1;
      if (seqEnd && !fifoMode) convPointer_d = '0;
    end else if (seqEnd && !fifoMode) begin
      convPointer_d = '0;
    end

    // with scan on, the sequencer repeats and each end lands here
    if (seqEnd) seqDoneFlag_d = 1'b1;
    if (trigOverrunEvent) trigOverrunFlag_d = 1'b1;
    if (overwriteEvent) overwriteFlag_d = 1'b1;

    irqStatus_d = irqStatus_q;
    if (rdIrqStatus) irqStatus_d = '0;
    irqStatus_d = irqStatus_d | irqEvents;
    irq_d = |(irqStatus_d & irqMask_d);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl2_q <= CTL_RESET;
      ctl3_q <= CTL_RESET;
      ctl4_q <= CTL_RESET;
      ctl5_q <= CTL_RESET;
      test0_q <= TEST_RESET;
      test1_q <= TEST_RESET;
      irqMask_q <= MASK_RESET;
      irqStatus_q <= '0;
      seqDoneFlag_q <= 1'b0;
      trigOverrunFlag_q <= 1'b0;
      overwriteFlag_q <= 1'b0;
      convPointer_q <= '0;
      convDoneFlag_q <= '0;
      doneReadArmed_q <= 1'b0;
      results_q <= '{default: '0};
      trigSync_q <= 3'h0;
      seqStart_q <= 1'b0;
      seqAbort_q <= 1'b0;
      irq_q <= 1'b0;
      analogSelect_q <= '{source: SRC_EXTERNAL, channel: 3'h0};
      scanMode <= 1'b0;
      fifoMode <= 1'b0;
    end else begin
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      ctl4_q <= ctl4_d;
      ctl5_q <= ctl5_d;
      test0_q <= test0_d;
      test1_q <= test1_d;
      irqMask_q <= irqMask_d;
      irqStatus_q <= irqStatus_d;
      seqDoneFlag_q <= seqDoneFlag_d;
      trigOverrunFlag_q <= trigOverrunFlag_d;
      overwriteFlag_q <= overwriteFlag_d;
      convPointer_q <= convPointer_d;
      convDoneFlag_q <= convDoneFlag_d;
      doneReadArmed_q <= doneReadArmed_d;
      results_q <= results_d;
      trigSync_q <= trigSync_d;
      seqStart_q <= seqStart_d;
      seqAbort_q <= seqAbort_d;
      irq_q <= irq_d;
      analogSelect_q <= analogSelectNext;
      scanMode <= ctl5_d[CTL5_SCAN_BIT];
      fifoMode <= ctl3_d[CTL3_FIFO_BIT];
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign seqStart = seqStart_q;
  assign seqAbort = seqAbort_q;
  assign analogSelect = analogSelect_q;
  assign irq = irq_q;

endmodule // adc_status_test_regs

// >>> tb/adc_status_props.sv
`timescale 1ns/1ns
module adc_status_props
  import adc_status_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seqStart,
  input wire logic seqAbort
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic wrTaken;
  assign wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0];
  a_abort_on_ctl: assert property (wrTaken && s_axi_awaddr inside {8'h08, 8'h0c, 8'h10}
    |-> ##[1:2] seqAbort) else $error("control write gave no abort");
  a_start_on_write: assert property (wrTaken && s_axi_awaddr == 8'h14
    |-> ##[1:2] seqStart) else $error("start write gave no start");
  a_start_one_cycle: assert property (seqStart |=> !seqStart) else $error("start pulse too long");
  a_abort_one_cycle: assert property (seqAbort |=> !seqAbort) else $error("abort pulse too long");
  a_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hfc
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
endmodule // adc_status_props

bind adc_status_test_regs adc_status_props u_props (.*);

// >>> tb/adc_sequencer_model.sv
`timescale 1ns/1ns
module adc_sequencer_model
  import adc_status_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic seqStart,
  input wire logic seqAbort,
  input wire logic scanMode,
  input wire logic [3:0] seqLen,
  input wire logic [9:0] dataBase,
  output logic seqActive,
  output logic seqEnd,
  output convResult_s convResult
);
  logic [3:0] done;
  logic [3:0] gap;
  // slow conversions leave room to read status before the first result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seqActive <= 1'b0;
      seqEnd <= 1'b0;
      convResult <= '0;
      done <= '0;
      gap <= '0;
    end else begin
      seqEnd <= 1'b0;
      convResult.valid <= 1'b0;
      // idle data toggles so a stale value never passes for a result
      convResult.data <= ~convResult.data;
      gap <= gap + 4'h1;
      if (seqAbort) begin
        seqActive <= 1'b0;
      end else if (seqStart) begin
        seqActive <= 1'b1;
        done <= '0;
        gap <= '0;
      end else if (seqActive && gap == 4'hf) begin
        convResult.valid <= 1'b1;
        convResult.data <= dataBase + 10'(done);
        done <= done + 4'h1;
        if (done + 4'h1 == seqLen) begin
          seqEnd <= 1'b1;
          done <= '0;
          seqActive <= scanMode;
        end
      end
    end
  end
endmodule // adc_sequencer_model

// >>> tb/adc_status_test_regs_tb.sv
`timescale 1ns/1ns
module adc_status_test_regs_tb
  import adc_status_pkg::*;
;
  logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic specialMode, extTrigger, seqActive, seqEnd, seqStart, seqAbort, scanMode, fifoMode, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
  logic [3:0] s_axi_wstrb, seqLen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0] dataBase;
  convResult_s convResult;
  analogSelect_s analogSelect;
  int miscompares, n_tests, cycles;
  logic [2:0] codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  source_e srcs [5] = '{SRC_REF_HIGH, SRC_REF_LOW, SRC_REF_MID, SRC_RESERVED, SRC_RESERVED};

  adc_status_test_regs dut (.*);
  adc_sequencer_model seqModel (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input regIndex_t idx, input logic [7:0] val,
                     output logic [31:0] data, output logic [1:0] resp);
    logic awPend, wPend, arPend;
    awPend = wr;
    wPend = wr;
    arPend = !wr;
    data = '0;
    if (wr) begin
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each channel drops its valid at its own handshake
      do begin
        @(posedge clk);
        if (awPend && s_axi_awready) begin
          awPend = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (wPend && s_axi_wready) begin
          wPend = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end else begin
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clk);
        if (arPend && s_axi_arready) begin
          arPend = 1'b0;
          s_axi_arvalid <= 1'b0;
        end
      end while (!s_axi_rvalid);
      resp = s_axi_rresp;
      data = s_axi_rdata;
      s_axi_rready <= 1'b0;
    end
    // idle edge so the next call never reassigns a ready in this step
    @(posedge clk);
  endtask

  task automatic wreg(input regIndex_t idx, input logic [7:0] val);
    acc(1'b1, idx, val, rdData, rsp);
    check(32'(rsp), 32'(RESP_OKAY));
  endtask

  task automatic rchk(input regIndex_t idx, input logic [31:0] exp, input logic [31:0] mask = '1);
    acc(1'b0, idx, 8'h00, rdData, rsp);
    check(rdData & mask, exp);
  endtask

  task automatic waitEnds(input int n);
    while (n > 0) begin
      @(posedge clk);
      if (seqEnd) n--;
    end
  endtask

  // covers the three-flop synchroniser and edge detect
  task automatic pin(input logic v);
    extTrigger <= v;
    repeat (6) @(posedge clk);
  endtask

  task close_out;
    $display("counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {specialMode, extTrigger, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    seqLen = 4'd3;
    dataBase = 10'h3a0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wreg(IDX_CTL5, 8'h00);
    waitEnds(1);
    rchk(IDX_STATUS0, 32'h80);
    rchk(IDX_CONV_DONE, 32'h07);
    check(32'(irq), 32'h0);
    wreg(IDX_IRQ_MASK, 8'h01);
    check(32'(irq), 32'h1);
    rchk(IDX_IRQ_STATUS, 32'h01);
    rchk(IDX_IRQ_STATUS, 32'h00);
    check(32'(irq), 32'h0);
    for (int i = 0; i < 3; i++) rchk(IDX_RESULT_BASE + 6'(i), 32'h3a0 + i);
    wreg(IDX_STATUS0, 8'h80);
    rchk(IDX_STATUS0, 32'h00);
    $display("test single sequence done");
    wreg(IDX_CTL5, 8'h20);
    check(32'(scanMode), 32'h1);
    waitEnds(2);
    wreg(IDX_CTL4, 8'h00);
    rchk(IDX_STATUS0, 32'h90);
    wreg(IDX_CTL5, 8'h00);
    rchk(IDX_STATUS0, 32'h00);
    waitEnds(1);
    $display("test scan overwrite done");
    seqLen <= 4'd5;
    wreg(IDX_CTL3, 8'h04);
    check(32'(fifoMode), 32'h1);
    wreg(IDX_CTL2, 8'h0c);
    pin(1'b1);
    waitEnds(1);
    rchk(IDX_STATUS0, 32'h95);
    wreg(IDX_STATUS0, 8'h17);
    rchk(IDX_STATUS0, 32'h85);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    pin(1'b1);
    waitEnds(1);
    rchk(IDX_STATUS0, 32'hb2);
    rchk(IDX_IRQ_STATUS, 32'h07);
    wreg(IDX_CTL4, 8'h00);
    rchk(IDX_STATUS0, 32'h90);
    wreg(IDX_CTL2, 8'h40);
    rchk(IDX_RESULT_BASE, 32'h3a3);
    rchk(IDX_STATUS0, 32'h10);
    wreg(IDX_CTL3, 8'h00);
    check(32'(fifoMode), 32'h0);
    // level mode with the pin still high starts at once and never overruns
    wreg(IDX_CTL2, 8'h1c);
    waitEnds(1);
    rchk(IDX_STATUS0, 32'h80, 32'ha7);
    wreg(IDX_CTL2, 8'h00);
    $display("test trigger fifo done");
    wreg(IDX_TEST1, 8'h01);
    rchk(IDX_TEST1, 32'h01, 32'h3f);
    for (int i = 0; i < 5; i++) begin
      wreg(IDX_CTL5, {5'h0, codes[i]});
      check(32'(analogSelect.source), 32'(srcs[i]));
    end
    wreg(IDX_TEST1, 8'h00);
    wreg(IDX_CTL5, 8'h03);
    check(32'(analogSelect), 32'({SRC_EXTERNAL, 3'h3}));
    wreg(IDX_CTL4, 8'h00);
    $display("test special channel done");
    wreg(IDX_TEST0, 8'h5a);
    rchk(IDX_TEST0, 32'h00);
    specialMode <= 1'b1;
    wreg(IDX_TEST0, 8'h5a);
    rchk(IDX_TEST0, 32'h5a);
    wreg(IDX_TEST0, 8'h00);
    specialMode <= 1'b0;
    acc(1'b0, 6'h3f, 8'h00, rdData, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    acc(1'b1, 6'h3f, 8'h11, rdData, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    $display("test reserved and unmapped done");
    close_out();
  end
endmodule // adc_status_test_regs_tb
